//--- uart_flags_consts.svh
// offsets, field positions, reset values and timing counts
`ifndef UART_FLAGS_CONSTS_SVH
`define UART_FLAGS_CONSTS_SVH
`define OFS_CTRL      8'h00
`define OFS_DATA      8'h04
`define OFS_CONFIG    8'h08
`define OFS_MASK      8'h0C
`define POS_THE       5
`define POS_REN       4
`define POS_TBX       3
`define POS_RBX       2
`define POS_TI        1
`define POS_RI        0
`define POS_XBE       0
`define POS_PEN       1
`define POS_PODD      2
`define CTRL_RESET    8'h20
`define MASK_RESET    2'h0
`define CLK_NS        10
`define BIT_TIME_NS   8680
`define BIT_CYCLES    ((`BIT_TIME_NS + `CLK_NS - 1) / `CLK_NS)
`define FIFO_AW       2
`define FIFO_DEPTH    4
`endif

//--- uart_flags_pkg.sv
// state types of the serial flag block
package uart_flags_pkg;
    typedef enum logic [2:0] {
        tx_idle, tx_start, tx_data, tx_extra, tx_stop
    } tx_state_type;
    typedef enum logic [2:0] {
        rx_idle, rx_start, rx_data, rx_extra, rx_stop
    } rx_state_type;
endpackage

//--- rx_byte_store.sv
// small receive byte store with registered head data
`timescale 1ns/100ps
`include "uart_flags_consts.svh"
module rx_byte_store (
    input  wire logic                sys_clk,
    input  wire logic                srst,
    input  wire logic                push,
    input  wire logic [7:0]          push_data,
    input  wire logic                pop,
    output logic      [7:0]          head_data,
    output logic      [`FIFO_AW:0]   count
);
    logic [7:0]          mem [`FIFO_DEPTH];
    logic [`FIFO_AW-1:0] wr_ptr;
    logic [`FIFO_AW-1:0] rd_ptr;
    logic [`FIFO_AW-1:0] next_wr_ptr;
    logic [`FIFO_AW-1:0] next_rd_ptr;
    logic [`FIFO_AW:0]   next_count;
    logic                do_push;
    logic                do_pop;

    always_comb begin
        do_push     = push && (count != `FIFO_DEPTH);
        do_pop      = pop && (count != '0);
        next_wr_ptr = do_push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = do_pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count  = count;
        if (do_push && !do_pop) begin
            next_count = count + 1'b1;
        end else if (do_pop && !do_push) begin
            next_count = count - 1'b1;
        end
    end

    // head lags a pointer move by one cycle; bus reads wait one cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            head_data <= 8'h00;
        end else begin
            wr_ptr    <= next_wr_ptr;
            rd_ptr    <= next_rd_ptr;
            count     <= next_count;
            head_data <= mem[rd_ptr];
        end
        if (do_push) begin
            mem[wr_ptr] <= push_data;
        end
    end
endmodule // rx_byte_store

//--- uart_serial_control_flags.sv
// serial control/status flags, transmitter, receiver and bus slave
//
// Behaviour
// - empty flag set when holding register free
// - receiver starts a frame only while enabled; a frame already begun completes after disable
// - stored bytes readable while receiver disabled
// - extra bit sent as transmit extra field
// - transmit extra field ignored under parity
// - received extra bit captured when enabled
// - otherwise first stop bit captured
// - transmit flag set at stop start
// - unmasked transmit flag raises interrupt
// - transmit flag cleared only by software
// - receive flag set on complete byte
//
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/100ps
`include "uart_flags_consts.svh"
module uart_serial_control_flags (
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic        rxd,
    output logic             txd,
    output logic             irq
);
    localparam int BITS = `BIT_CYCLES;

    function automatic logic [3:0] frame_len(input logic xbe,
                                             input logic pen);
        return (xbe || pen) ? 4'd9 : 4'd8;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // bus slave: every transfer takes one wait state
    logic       pending, waited, wr_q;
    logic [7:0] addr_q;
    logic       next_pending, next_waited, next_wr_q;
    logic [7:0] next_addr_q;
    logic [31:0] next_hrdata;
    logic       done, wr_ctrl, wr_data, wr_cfg, wr_mask, rd_data;

    logic [7:0]  head_data;
    logic [`FIFO_AW:0] count;
    logic        tx_holding_empty, rx_enable_bit, tx_extra_bit;
    logic        rx_extra_bit, tx_irq_flag, rx_irq_flag;
    logic        extra_bit_enable, parity_en, parity_odd;
    logic [1:0]  irq_mask;

    assign hreadyout = !pending || waited;
    assign hresp     = 1'b0;
    assign done      = pending && waited;
    assign wr_ctrl   = done && wr_q && addr_q == `OFS_CTRL;
    assign wr_data   = done && wr_q && addr_q == `OFS_DATA;
    assign wr_cfg    = done && wr_q && addr_q == `OFS_CONFIG;
    assign wr_mask   = done && wr_q && addr_q == `OFS_MASK;
    assign rd_data   = done && !wr_q && addr_q == `OFS_DATA;

    always_comb begin
        next_pending = pending && !waited;
        next_waited  = pending && !waited;
        next_addr_q  = addr_q;
        next_wr_q    = wr_q;
        next_hrdata  = hrdata;
        if (hsel && hready && htrans[1]) begin
            next_pending = 1'b1;
            next_waited  = 1'b0;
            next_addr_q  = haddr[7:0];
            next_wr_q    = hwrite;
        end
        if (pending && !waited) begin
            unique case (addr_q)
                `OFS_CTRL: next_hrdata = {26'h0, tx_holding_empty,
                    rx_enable_bit, tx_extra_bit, rx_extra_bit,
                    tx_irq_flag, rx_irq_flag};
                `OFS_DATA: next_hrdata = {24'h0, head_data};
                `OFS_CONFIG: next_hrdata = {29'h0, parity_odd,
                    parity_en, extra_bit_enable};
                `OFS_MASK: next_hrdata = {30'h0, irq_mask};
                default: next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pending <= 1'b0;
            waited  <= 1'b0;
            addr_q  <= 8'h00;
            wr_q    <= 1'b0;
            hrdata  <= 32'h0000_0000;
        end else begin
            pending <= next_pending;
            waited  <= next_waited;
            addr_q  <= next_addr_q;
            wr_q    <= next_wr_q;
            hrdata  <= next_hrdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control, flags and mask
    logic       tx_set, rx_set, rx_xbit_load, rx_xbit_val;
    logic       hold_full, next_hold_full;
    logic [7:0] hold, next_hold;
    logic       next_ren, next_tbx, next_rbx, next_ti, next_ri;
    logic       next_xbe, next_pen, next_podd;
    logic [1:0] next_mask;
    logic       load_shift;

    assign tx_holding_empty = !hold_full;
    assign irq = |({tx_irq_flag, rx_irq_flag} & irq_mask);

    always_comb begin
        next_ren  = wr_ctrl ? hwdata[`POS_REN] : rx_enable_bit;
        next_tbx  = wr_ctrl ? hwdata[`POS_TBX] : tx_extra_bit;
        next_rbx  = rx_xbit_load ? rx_xbit_val : rx_extra_bit;
        // set beats a clear in the same cycle
        next_ti = tx_set || (tx_irq_flag &&
                  !(wr_ctrl && hwdata[`POS_TI]));
        next_ri = rx_set || (rx_irq_flag &&
                  !(wr_ctrl && hwdata[`POS_RI]));
        next_xbe  = wr_cfg ? hwdata[`POS_XBE] : extra_bit_enable;
        next_pen  = wr_cfg ? hwdata[`POS_PEN] : parity_en;
        next_podd = wr_cfg ? hwdata[`POS_PODD] : parity_odd;
        next_mask = wr_mask ? hwdata[1:0] : irq_mask;
        next_hold = hold;
        next_hold_full = hold_full && !load_shift;
        // a write while occupied is dropped, not queued
        if (wr_data && !hold_full) begin
            next_hold      = hwdata[7:0];
            next_hold_full = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rx_enable_bit    <= 1'((`CTRL_RESET >> `POS_REN) & 8'h01);
            tx_extra_bit     <= 1'b0;
            rx_extra_bit     <= 1'b0;
            tx_irq_flag      <= 1'b0;
            rx_irq_flag      <= 1'b0;
            extra_bit_enable <= 1'b0;
            parity_en        <= 1'b0;
            parity_odd       <= 1'b0;
            irq_mask         <= `MASK_RESET;
            hold             <= 8'h00;
            hold_full        <= 1'b0;
        end else begin
            rx_enable_bit    <= next_ren;
            tx_extra_bit     <= next_tbx;
            rx_extra_bit     <= next_rbx;
            tx_irq_flag      <= next_ti;
            rx_irq_flag      <= next_ri;
            extra_bit_enable <= next_xbe;
            parity_en        <= next_pen;
            parity_odd       <= next_podd;
            irq_mask         <= next_mask;
            hold             <= next_hold;
            hold_full        <= next_hold_full;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // transmitter
    uart_flags_pkg::tx_state_type tx_state, next_tx_state;
    logic [9:0] tx_cnt, next_tx_cnt;
    logic [3:0] tx_idx, next_tx_idx;
    logic [7:0] tx_shift, next_tx_shift;
    logic       next_txd, tx_xbit, next_tx_xbit;

    always_comb begin
        next_tx_state = tx_state;
        next_tx_cnt   = (tx_cnt == '0) ? 10'(BITS - 1) : tx_cnt - 1'b1;
        next_tx_idx   = tx_idx;
        next_tx_shift = tx_shift;
        next_tx_xbit  = tx_xbit;
        next_txd      = txd;
        load_shift    = 1'b0;
        tx_set        = 1'b0;
        unique case (tx_state)
            uart_flags_pkg::tx_idle: begin
                next_tx_cnt = 10'(BITS - 1);
                if (hold_full) begin
                    load_shift    = 1'b1;
                    next_tx_shift = hold;
                    next_tx_xbit  = parity_en ? (^hold ^ parity_odd)
                                              : tx_extra_bit;
                    next_tx_idx   = 4'd0;
                    next_txd      = 1'b0;
                    next_tx_state = uart_flags_pkg::tx_start;
                end
            end
            uart_flags_pkg::tx_start, uart_flags_pkg::tx_data: begin
                if (tx_cnt == '0) begin
                    if (tx_idx == 4'd8) begin
                        next_txd = tx_xbit;
                        next_tx_state = uart_flags_pkg::tx_extra;
                    end else begin
                        next_txd      = tx_shift[0];
                        next_tx_shift = tx_shift >> 1;
                        next_tx_idx   = tx_idx + 1'b1;
                        next_tx_state = uart_flags_pkg::tx_data;
                    end
                    if (tx_idx == frame_len(extra_bit_enable,
                                            parity_en)) begin
                        next_txd      = 1'b1;
                        tx_set        = 1'b1;
                        next_tx_state = uart_flags_pkg::tx_stop;
                    end
                end
            end
            uart_flags_pkg::tx_extra: begin
                if (tx_cnt == '0) begin
                    next_txd      = 1'b1;
                    tx_set        = 1'b1;
                    next_tx_state = uart_flags_pkg::tx_stop;
                end
            end
            uart_flags_pkg::tx_stop: begin
                if (tx_cnt == '0) begin
                    next_tx_state = uart_flags_pkg::tx_idle;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tx_state <= uart_flags_pkg::tx_idle;
            tx_cnt   <= 10'h000;
            tx_idx   <= 4'h0;
            tx_shift <= 8'h00;
            tx_xbit  <= 1'b0;
            txd      <= 1'b1;
        end else begin
            tx_state <= next_tx_state;
            tx_cnt   <= next_tx_cnt;
            tx_idx   <= next_tx_idx;
            tx_shift <= next_tx_shift;
            tx_xbit  <= next_tx_xbit;
            txd      <= next_txd;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // receiver; the line passes two flops before any use
    uart_flags_pkg::rx_state_type rx_state, next_rx_state;
    logic       rxd_meta, rxd_s;
    logic [9:0] rx_cnt, next_rx_cnt;
    logic [3:0] rx_idx, next_rx_idx;
    logic [7:0] rx_shift, next_rx_shift;
    logic       rx_x, next_rx_x;

    always_comb begin
        next_rx_state = rx_state;
        next_rx_cnt   = (rx_cnt == '0) ? 10'(BITS - 1) : rx_cnt - 1'b1;
        next_rx_idx   = rx_idx;
        next_rx_shift = rx_shift;
        next_rx_x     = rx_x;
        rx_set        = 1'b0;
        rx_xbit_load  = 1'b0;
        rx_xbit_val   = rx_x;
        unique case (rx_state)
            uart_flags_pkg::rx_idle: begin
                next_rx_cnt = 10'(BITS / 2 - 1);
                if (rx_enable_bit && !rxd_s) begin
                    next_rx_state = uart_flags_pkg::rx_start;
                end
            end
            uart_flags_pkg::rx_start: begin
                if (rx_cnt == '0) begin
                    next_rx_idx   = 4'd0;
                    next_rx_state = rxd_s ? uart_flags_pkg::rx_idle
                                          : uart_flags_pkg::rx_data;
                end
            end
            uart_flags_pkg::rx_data: begin
                if (rx_cnt == '0) begin
                    next_rx_shift = {rxd_s, rx_shift[7:1]};
                    next_rx_idx   = rx_idx + 1'b1;
                    if (rx_idx == 4'd7) begin
                        next_rx_state = (frame_len(extra_bit_enable,
                            parity_en) == 4'd9) ? uart_flags_pkg::rx_extra
                                                : uart_flags_pkg::rx_stop;
                    end
                end
            end
            uart_flags_pkg::rx_extra: begin
                if (rx_cnt == '0) begin
                    next_rx_x     = rxd_s;
                    next_rx_state = uart_flags_pkg::rx_stop;
                end
            end
            uart_flags_pkg::rx_stop: begin
                if (rx_cnt == '0) begin
                    rx_set        = 1'b1;
                    rx_xbit_load  = 1'b1;
                    rx_xbit_val   = extra_bit_enable ? rx_x
                                                     : rxd_s;
                    next_rx_state = uart_flags_pkg::rx_idle;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rxd_meta <= 1'b1;
            rxd_s    <= 1'b1;
            rx_state <= uart_flags_pkg::rx_idle;
            rx_cnt   <= 10'h000;
            rx_idx   <= 4'h0;
            rx_shift <= 8'h00;
            rx_x     <= 1'b0;
        end else begin
            rxd_meta <= rxd;
            rxd_s    <= rxd_meta;
            rx_state <= next_rx_state;
            rx_cnt   <= next_rx_cnt;
            rx_idx   <= next_rx_idx;
            rx_shift <= next_rx_shift;
            rx_x     <= next_rx_x;
        end
    end

    // pops do not depend on the receive enable
    rx_byte_store store (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .push      (rx_set),
        .push_data (rx_shift),
        .pop       (rd_data),
        .head_data (head_data),
        .count     (count)
    );

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    a_empty_clears: assert property (wr_data && !hold_full |=> !tx_holding_empty)
        else $error("empty flag still set after load");
    a_rx_held_off: assert property (!rx_enable_bit && rx_state == uart_flags_pkg::rx_idle |=> rx_state == uart_flags_pkg::rx_idle)
        else $error("receiver started while disabled");
    a_pop_disabled: assert property (rd_data && count != '0 && !rx_enable_bit && !rx_set |=> count == $past(count) - 1'b1)
        else $error("byte not popped while disabled");
    a_tx_extra_level: assert property (tx_state == uart_flags_pkg::tx_extra && $past(tx_state) != uart_flags_pkg::tx_extra && extra_bit_enable && !parity_en && !$past(wr_ctrl, 2) |-> txd == tx_extra_bit)
        else $error("extra bit level wrong");
    a_tx_flag_stop: assert property (tx_state == uart_flags_pkg::tx_stop && $past(tx_state) != uart_flags_pkg::tx_stop |-> tx_irq_flag && txd)
        else $error("transmit flag not set at stop");
    a_tx_irq_out: assert property (tx_irq_flag && irq_mask[1] |-> irq)
        else $error("interrupt not raised");
    a_tx_flag_sticky: assert property (tx_irq_flag && !(wr_ctrl && hwdata[`POS_TI]) |=> tx_irq_flag)
        else $error("transmit flag dropped by itself");
    a_rx_flag_set: assert property (rx_state == uart_flags_pkg::rx_stop ##1 rx_state == uart_flags_pkg::rx_idle |-> rx_irq_flag)
        else $error("receive flag not set");
    a_rx_xbit: assert property (rx_xbit_load |=> rx_extra_bit == ($past(extra_bit_enable) ? $past(rx_x) : $past(rxd_s)))
        else $error("receive extra bit wrong");

    c_tx_frame: cover property (tx_state == uart_flags_pkg::tx_stop ##1 tx_state == uart_flags_pkg::tx_idle);
    c_rx_byte: cover property (rx_set && extra_bit_enable);
    c_set_vs_clear: cover property (tx_set && wr_ctrl && hwdata[`POS_TI]);
endmodule // uart_serial_control_flags

//--- serial_peer.sv
// remote serial peer: drives the receive line, captures the transmit line
`timescale 1ns/100ps
`include "uart_flags_consts.svh"
module serial_peer (
    input  wire logic sys_clk,
    input  wire logic txd,
    output logic      rxd
);
    // idle high, as the line rests between frames
    initial rxd = 1'b1;

    ////////////////////////////////////////
    task automatic drive_bit(input logic v);
        rxd <= v;
        repeat (`BIT_CYCLES) @(posedge sys_clk);
    endtask

    // lsb first, optional ninth bit, one stop bit
    task automatic send_frame(input logic [7:0] d, input logic nine,
                              input logic b9);
        @(posedge sys_clk);
        drive_bit(1'b0);
        for (int i = 0; i < 8; i++) begin
            drive_bit(d[i]);
        end
        if (nine) begin
            drive_bit(b9);
        end
        drive_bit(1'b1);
    endtask

    // returns at mid stop bit, where the sent flag is already up
    task automatic recv_frame(input logic nine, output logic [7:0] d,
                              output logic b9);
        b9 = 1'b0;
        while (txd !== 1'b0) @(posedge sys_clk);
        repeat (`BIT_CYCLES / 2) @(posedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (`BIT_CYCLES) @(posedge sys_clk);
            d[i] = txd;
        end
        if (nine) begin
            repeat (`BIT_CYCLES) @(posedge sys_clk);
            b9 = txd;
        end
        repeat (`BIT_CYCLES) @(posedge sys_clk);
    endtask
endmodule // serial_peer

//--- tb.sv
// self-checking bench of the serial control flag block
`timescale 1ns/100ps
`include "uart_flags_consts.svh"
module tb;
    logic        sys_clk;
    logic        srst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        rxd;
    logic        txd;
    logic        irq;
    int          fail_count = 0;
    int          comparisons = 0;

    uart_serial_control_flags u_dut (
        .sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .rxd(rxd), .txd(txd),
        .irq(irq)
    );

    serial_peer u_peer (.sys_clk(sys_clk), .txd(txd), .rxd(rxd));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check_word(input string n, input logic [31:0] e,
                              input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic check_bit(input string n, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %b seen %b", n, e, g);
        end
    endtask

    // single word transfer; no fixed wait assumed, the watchdog bounds it
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h000000, a};
        hwrite <= wr;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        rd = hrdata;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        bus(1'b1, a, d, unused);
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        bus(1'b0, a, 32'h00000000, d);
    endtask

    ////////////////////////////////////////
    task automatic reset_values();
        logic [31:0] v;
        reg_read(`OFS_CTRL, v);
        check_word("ctrl_reset", 32'h00000020, v);
        reg_read(`OFS_MASK, v);
        check_word("mask_reset", 32'h00000000, v);
        reg_write(8'h10, 32'h000000FF);
        reg_read(8'h10, v);
        check_word("unmapped", 32'h00000000, v);
        check_bit("irq_reset", 1'b0, irq);
        check_bit("hresp_okay", 1'b0, hresp);
    endtask

    // second byte waits in the holding register behind the first
    task automatic tx_queue();
        logic [31:0] v;
        logic [7:0]  d;
        logic        b9;
        reg_write(`OFS_MASK, 32'h00000002);
        reg_write(`OFS_DATA, 32'h000000A5);
        reg_write(`OFS_DATA, 32'h0000003C);
        reg_read(`OFS_CTRL, v);
        check_word("ctrl_full", 32'h00000000, v);
        u_peer.recv_frame(1'b0, d, b9);
        check_word("tx_byte1", 32'h000000A5, {24'h000000, d});
        @(negedge sys_clk);
        check_bit("irq_tx1", 1'b1, irq);
        reg_write(`OFS_CTRL, 32'h00000002);
        @(negedge sys_clk);
        check_bit("irq_clr", 1'b0, irq);
        u_peer.recv_frame(1'b0, d, b9);
        check_word("tx_byte2", 32'h0000003C, {24'h000000, d});
        @(negedge sys_clk);
        check_bit("irq_tx2", 1'b1, irq);
        repeat (2 * `BIT_CYCLES) @(posedge sys_clk);
        reg_read(`OFS_CTRL, v);
        check_word("ctrl_ti_held", 32'h00000022, v);
        reg_write(`OFS_CTRL, 32'h00000002);
        reg_read(`OFS_CTRL, v);
        check_word("ctrl_ti_clr", 32'h00000020, v);
    endtask

    // ninth bit: extra field, then even and odd parity overriding it
    task automatic extra_bits();
        logic [7:0]  cfg [3] = '{8'h01, 8'h03, 8'h07};
        logic [7:0]  ctl [3] = '{8'h08, 8'h08, 8'h00};
        logic [7:0]  dat [3] = '{8'h3C, 8'h03, 8'h03};
        logic        want9 [3] = '{1'b1, 1'b0, 1'b1};
        logic [31:0] v;
        logic [7:0]  d;
        logic        b9;
        reg_write(`OFS_MASK, 32'h00000000);
        for (int i = 0; i < 3; i++) begin
            reg_write(`OFS_CONFIG, {24'h000000, cfg[i]});
            reg_write(`OFS_CTRL, {24'h000000, ctl[i]});
            reg_write(`OFS_DATA, {24'h000000, dat[i]});
            u_peer.recv_frame(1'b1, d, b9);
            check_word("tx_data9", {24'h000000, dat[i]}, {24'h000000, d});
            check_bit("tx_bit9", want9[i], b9);
            @(negedge sys_clk);
            check_bit("irq_masked", 1'b0, irq);
        end
        reg_read(`OFS_CTRL, v);
        check_word("ti_masked", 32'h00000002, v & 32'h00000002);
        reg_write(`OFS_CTRL, 32'h00000002);
    endtask

    // a frame while disabled must leave no trace in the store
    task automatic rx_path();
        logic [31:0] v;
        reg_write(`OFS_MASK, 32'h00000001);
        reg_write(`OFS_CONFIG, 32'h00000000);
        u_peer.send_frame(8'h55, 1'b0, 1'b0);
        reg_read(`OFS_CTRL, v);
        check_word("ctrl_rx_off", 32'h00000020, v);
        reg_write(`OFS_CONFIG, 32'h00000001);
        reg_write(`OFS_CTRL, 32'h00000010);
        u_peer.send_frame(8'h96, 1'b1, 1'b0);
        reg_read(`OFS_CTRL, v);
        check_word("ctrl_rx9", 32'h00000031, v);
        @(negedge sys_clk);
        check_bit("irq_rx", 1'b1, irq);
        reg_write(`OFS_CTRL, 32'h00000011);
        @(negedge sys_clk);
        check_bit("irq_rx_clr", 1'b0, irq);
        reg_write(`OFS_CONFIG, 32'h00000000);
        u_peer.send_frame(8'h5A, 1'b0, 1'b0);
        reg_read(`OFS_CTRL, v);
        check_word("ctrl_rx8", 32'h00000035, v);
        reg_write(`OFS_CTRL, 32'h00000001);
        reg_read(`OFS_DATA, v);
        check_word("rx_byte1", 32'h00000096, v);
        reg_read(`OFS_DATA, v);
        check_word("rx_byte2", 32'h0000005A, v);
        reg_read(`OFS_CTRL, v);
        check_word("ctrl_rx_end", 32'h00000024, v);
    endtask

    ////////////////////////////////////////
    initial begin
        srst   = 1'b1;
        hsel   = 1'b0;
        haddr  = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h00000000;
        repeat (20) @(posedge sys_clk);
        srst <= 1'b0;
        reset_values();
        tx_queue();
        extra_bits();
        rx_path();
        tally_and_finish();
    end

    // eight frames, about 85 bit times, stay well below 95,000 cycles
    initial begin
        #950000;
        fail_count++;
        tally_and_finish();
    end
endmodule // tb
